/* phy_ctrl_pkg.sv */
// Package: control register layout, reset values and timing counts
package phy_ctrl_pkg;

  // Register offset on the management link
  localparam logic [4:0] PHY_BASIC_CONTROL_OFS = 5'h00;

  // Field positions
  localparam int BIT_RESET = 15;
  localparam int BIT_LOOPBACK = 14;
  localparam int BIT_SPEED = 13;
  localparam int BIT_ANEG_EN = 12;
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_ISOLATE = 10;
  localparam int BIT_RESTART = 9;
  localparam int BIT_DUPLEX = 8;
  localparam int BIT_COL_TEST = 7;

  // Reset values of the stored fields
  localparam logic RST_LOOPBACK = 1'h0;
  localparam logic RST_SPEED = 1'h1;
  localparam logic RST_ANEG_EN = 1'h1;
  localparam logic RST_POWER_DOWN = 1'h0;
  localparam logic RST_ISOLATE = 1'h0;
  localparam logic RST_DUPLEX = 1'h0;
  localparam logic RST_COL_TEST = 1'h1;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SOFT_RESET_NS = 200;
  localparam int DEAD_TIME_NS = 560;
  localparam int SOFT_RESET_CYCLES_I = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_CYCLES_I = DEAD_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] SOFT_RESET_CYCLES = 8'(SOFT_RESET_CYCLES_I);
  localparam logic [7:0] DEAD_CYCLES = 8'(DEAD_CYCLES_I);

  // Stored control fields
  typedef struct packed {
    logic loopback;
    logic speed;
    logic aneg_en;
    logic power_down;
    logic isolate;
    logic duplex;
    logic col_test;
  } ctrl_type;

  localparam ctrl_type CTRL_DEFAULT = '{
    loopback: RST_LOOPBACK,
    speed: RST_SPEED,
    aneg_en: RST_ANEG_EN,
    power_down: RST_POWER_DOWN,
    isolate: RST_ISOLATE,
    duplex: RST_DUPLEX,
    col_test: RST_COL_TEST
  };

  // One nibble of media-independent data
  typedef struct packed {
    logic en;
    logic [3:0] data;
  } nibble_type;

endpackage

/* phy_cycle_timer.sv */
// Down counter that stays busy for a loaded number of cycles
`timescale 1ns/1ps
module phy_cycle_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_q,
  // Control
  input wire logic start,
  input wire logic [7:0] cycles,
  // Status
  output logic busy
);

  logic [7:0] count_q;

  // Load on start, count down to zero
  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      count_q <= 8'h00;
    end else if (start) begin
      count_q <= cycles;
    end else if (count_q != 8'h00) begin
      count_q <= count_q - 8'h01;
    end
  end

  assign busy = (count_q != 8'h00);

endmodule // phy_cycle_timer

/* phy_control_register.sv */
// Basic control register of the physical-layer device and the paths it steers
`timescale 1ns/1ps
module phy_control_register (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Management access, one pulse per complete frame
  input wire logic mgmt_wr_valid,
  input wire logic [15:0] mgmt_wr_data,
  output logic [15:0] mgmt_rd_data,
  // Negotiation and power
  input wire logic aneg_speed_100,
  input wire logic aneg_full_duplex,
  input wire logic link_power_down,
  input wire logic medium_side_loopback_bit,
  output logic aneg_enable,
  output logic aneg_restart,
  output logic speed_100,
  output logic full_duplex,
  output logic low_power,
  output logic soft_reset,
  output logic medium_loopback_en,
  // Host-side transmit and receive
  input wire phy_ctrl_pkg::nibble_type host_tx,
  output phy_ctrl_pkg::nibble_type host_rx,
  // Line-side transmit and receive
  input wire phy_ctrl_pkg::nibble_type line_rx,
  output phy_ctrl_pkg::nibble_type line_tx
);
  import phy_ctrl_pkg::*;

  logic rst_meta_q;
  logic rst_q;
  ctrl_type ctrl_q;
  logic restart_q;
  logic loop_prev_q;
  logic reset_busy;
  logic dead_busy;
  logic wr_ok;
  logic reset_start;
  logic dead_start;
  logic [15:0] rd_view;
  nibble_type rx_q;
  nibble_type tx_q;
  logic [15:0] rd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write acceptance, ignored while a soft reset runs
  assign wr_ok = mgmt_wr_valid && !reset_busy;
  assign reset_start = wr_ok && mgmt_wr_data[BIT_RESET];

  // Soft reset duration
  phy_cycle_timer reset_timer (
    .clock(clock),
    .rst_q(rst_q),
    .start(reset_start),
    .cycles(SOFT_RESET_CYCLES),
    .busy(reset_busy)
  );

  // Control fields, updated whole from one frame; bits 6 to 0 are not stored
  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      ctrl_q <= CTRL_DEFAULT;
    end else if (reset_start || reset_busy) begin
      ctrl_q <= CTRL_DEFAULT;
    end else if (wr_ok) begin
      ctrl_q.loopback <= mgmt_wr_data[BIT_LOOPBACK];
      ctrl_q.speed <= mgmt_wr_data[BIT_SPEED];
      ctrl_q.aneg_en <= mgmt_wr_data[BIT_ANEG_EN];
      ctrl_q.power_down <= mgmt_wr_data[BIT_POWER_DOWN];
      ctrl_q.isolate <= mgmt_wr_data[BIT_ISOLATE];
      ctrl_q.duplex <= mgmt_wr_data[BIT_DUPLEX];
      ctrl_q.col_test <= mgmt_wr_data[BIT_COL_TEST];
    end
  end

  // Restart request, held one cycle then cleared by hardware
  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_ok && !mgmt_wr_data[BIT_RESET] && mgmt_wr_data[BIT_RESTART];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read view of the register
  always_comb begin
    rd_view = 16'h0000;
    rd_view[BIT_RESET] = reset_busy;
    rd_view[BIT_LOOPBACK] = ctrl_q.loopback;
    rd_view[BIT_SPEED] = ctrl_q.speed;
    rd_view[BIT_ANEG_EN] = ctrl_q.aneg_en;
    rd_view[BIT_POWER_DOWN] = ctrl_q.power_down;
    rd_view[BIT_ISOLATE] = ctrl_q.isolate;
    rd_view[BIT_RESTART] = restart_q;
    rd_view[BIT_DUPLEX] = ctrl_q.aneg_en ? 1'b1 : ctrl_q.duplex;
    rd_view[BIT_COL_TEST] = ctrl_q.col_test;
  end

  // Registered read data
  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      rd_q <= 16'h0000;
    end else begin
      rd_q <= rd_view;
    end
  end

  assign mgmt_rd_data = rd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode
  assign aneg_enable = ctrl_q.aneg_en;
  assign aneg_restart = restart_q;
  assign soft_reset = reset_busy;
  assign speed_100 = ctrl_q.aneg_en ? aneg_speed_100 : ctrl_q.speed;
  // Duplex bit ignored in loopback and under negotiation
  assign full_duplex = ctrl_q.loopback ? 1'b1 :
                       (ctrl_q.aneg_en ? aneg_full_duplex : ctrl_q.duplex);
  assign low_power = ctrl_q.power_down || link_power_down;
  assign medium_loopback_en = medium_side_loopback_bit && !ctrl_q.loopback;

  ////////////////////////////////////////////////////////////////////////////
  // Loopback entry blanking gap
  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      loop_prev_q <= 1'b0;
    end else begin
      loop_prev_q <= ctrl_q.loopback;
    end
  end

  assign dead_start = ctrl_q.loopback && !loop_prev_q;

  phy_cycle_timer dead_timer (
    .clock(clock),
    .rst_q(rst_q),
    .start(dead_start),
    .cycles(DEAD_CYCLES),
    .busy(dead_busy)
  );

  // Receive path toward the host
  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      rx_q <= '0;
    end else if (ctrl_q.isolate) begin
      rx_q <= '0;
    end else if (ctrl_q.loopback) begin
      rx_q.data <= host_tx.data;
      rx_q.en <= host_tx.en && !dead_busy && !dead_start;
    end else begin
      rx_q <= line_rx;
    end
  end

  // Transmit path toward the line
  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      tx_q <= '0;
    end else if (ctrl_q.isolate) begin
      tx_q <= '0;
    end else begin
      tx_q <= host_tx;
    end
  end

  assign host_rx = rx_q;
  assign line_tx = tx_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence reset_write_s;
    mgmt_wr_valid && !reset_busy && mgmt_wr_data[BIT_RESET];
  endsequence

  sequence restart_write_s;
    mgmt_wr_valid && !reset_busy && !mgmt_wr_data[BIT_RESET] && mgmt_wr_data[BIT_RESTART];
  endsequence

  reset_hold_a: assert property (@(posedge clock) disable iff (!rst_q)
    reset_write_s |=> reset_busy[*8] ##0 (ctrl_q == CTRL_DEFAULT))
    else $error("soft reset did not hold defaults");

  reset_read_a: assert property (@(posedge clock) disable iff (!rst_q)
    reset_busy |=> mgmt_rd_data[BIT_RESET])
    else $error("reset bit not read as one while busy");

  reset_end_a: assert property (@(posedge clock) disable iff (!rst_q)
    $fell(reset_busy) |-> ctrl_q == CTRL_DEFAULT ##1 !mgmt_rd_data[BIT_RESET])
    else $error("reset end wrong");

  loop_route_a: assert property (@(posedge clock) disable iff (!rst_q)
    ctrl_q.loopback && !ctrl_q.isolate |=> host_rx.data == $past(host_tx.data))
    else $error("loopback data not routed");

  dead_gap_a: assert property (@(posedge clock) disable iff (!rst_q)
    $rose(ctrl_q.loopback) && !ctrl_q.isolate ##1 ctrl_q.loopback[*8] |=> !host_rx.en)
    else $error("data delivered in loopback gap");

  loop_prio_a: assert property (@(posedge clock) disable iff (!rst_q)
    ctrl_q.loopback |-> !medium_loopback_en)
    else $error("medium loopback active with register loopback");

  speed_pick_a: assert property (@(posedge clock) disable iff (!rst_q)
    speed_100 == (ctrl_q.aneg_en ? aneg_speed_100 : ctrl_q.speed))
    else $error("speed selection wrong");

  power_or_a: assert property (@(posedge clock) disable iff (!rst_q)
    low_power == (ctrl_q.power_down || link_power_down))
    else $error("low power request not ORed");

  isolate_cut_a: assert property (@(posedge clock) disable iff (!rst_q)
    ctrl_q.isolate |=> !host_rx.en && !line_tx.en)
    else $error("isolated interface still active");

  restart_pulse_a: assert property (@(posedge clock) disable iff (!rst_q)
    restart_write_s |=> aneg_restart ##1 (!aneg_restart || $past(mgmt_wr_valid)))
    else $error("restart pulse wrong");

  duplex_ro_a: assert property (@(posedge clock) disable iff (!rst_q)
    ctrl_q.aneg_en |=> mgmt_rd_data[BIT_DUPLEX])
    else $error("duplex bit not one under negotiation");

  loop_duplex_a: assert property (@(posedge clock) disable iff (!rst_q)
    ctrl_q.loopback |-> full_duplex)
    else $error("duplex bit affects loopback");

  write_whole_a: assert property (@(posedge clock) disable iff (!rst_q)
    mgmt_wr_valid && !reset_busy && !mgmt_wr_data[BIT_RESET] |=>
      ctrl_q.col_test == $past(mgmt_wr_data[BIT_COL_TEST]) &&
      ctrl_q.speed == $past(mgmt_wr_data[BIT_SPEED]) &&
      ctrl_q.loopback == $past(mgmt_wr_data[BIT_LOOPBACK]))
    else $error("write not applied whole");

endmodule // phy_control_register

/* mgmt_host_model.sv */
// Host controller model issuing management write frames and polling reads
`timescale 1ns/1ps
module mgmt_host_model (
  // Clock
  input wire logic clock,
  // Management link
  input wire logic [15:0] mgmt_rd_data,
  output logic mgmt_wr_valid,
  output logic [15:0] mgmt_wr_data
);
  // Idle link at time zero
  initial begin
    mgmt_wr_valid = 1'h0;
    mgmt_wr_data = 16'h0000;
  end
  // One complete frame; data is scrambled once the frame is over
  task automatic wr(input logic [15:0] d);
    @(posedge clock);
    mgmt_wr_valid <= 1'h1;
    mgmt_wr_data <= {d[15:7], 7'h00};
    @(posedge clock);
    mgmt_wr_valid <= 1'h0;
    mgmt_wr_data <= ~d;
  endtask
  // Wait, bounded, until the reset bit reads zero
  task automatic poll(output logic ok);
    int n;
    ok = 1'h0;
    for (n = 0; n < 60 && !ok; n++) begin
      @(posedge clock);
      #1 ok = (mgmt_rd_data[15] === 1'h0);
    end
  endtask
endmodule // mgmt_host_model

/* phy_control_register_tb.sv */
// Self-checking bench for the basic control register
`timescale 1ns/1ps
module phy_control_register_tb;
  import phy_ctrl_pkg::*;
  logic clock, rstn, wv, spd_a, fdx_a, lpd, mlb, ok;
  logic [15:0] wd, rd;
  logic aen, rst_p, spd, fdx, lowp, srst, mlen;
  nibble_type host_tx, host_rx, line_rx, line_tx;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int n, hits;
  // Design and host model
  phy_control_register u_phy_control_register (.clock(clock), .rstn(rstn),
    .mgmt_wr_valid(wv), .mgmt_wr_data(wd), .mgmt_rd_data(rd),
    .aneg_speed_100(spd_a), .aneg_full_duplex(fdx_a), .link_power_down(lpd),
    .medium_side_loopback_bit(mlb), .aneg_enable(aen), .aneg_restart(rst_p),
    .speed_100(spd), .full_duplex(fdx), .low_power(lowp), .soft_reset(srst),
    .medium_loopback_en(mlen), .host_tx(host_tx), .host_rx(host_rx),
    .line_rx(line_rx), .line_tx(line_tx));
  mgmt_host_model u_mgmt_host_model (.clock(clock), .mgmt_rd_data(rd),
    .mgmt_wr_valid(wv), .mgmt_wr_data(wd));
  // Clock
  always #5 clock = ~clock;
  // Compare and count
  task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic tk(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [15:0] d);
    u_mgmt_host_model.wr(d);
  endtask
  // Verdict
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      final_report;
    end
  end
  // Main sequence
  initial begin
    clock = 1'h0; rstn = 1'h0; spd_a = 1'h0; fdx_a = 1'h1; lpd = 1'h0; mlb = 1'h0;
    host_tx = '0; line_rx = '0;
    repeat (5) @(posedge clock);
    rstn <= 1'h1;
    tk(8);
    chk("defaults", rd, 16'h3180);
    chk("aneg_enable", aen, 1'h1);
    chk("speed_aneg", spd, spd_a);
    wr(16'h0180); tk(2);
    chk("forced rd", rd, 16'h0180);
    chk("speed 10", spd, 1'h0);
    chk("full", fdx, 1'h1);
    wr(16'h2000); tk(2);
    chk("forced rd2", rd, 16'h2000);
    chk("speed 100", spd, 1'h1);
    chk("half", fdx, 1'h0);
    wr(16'h3000); tk(2);
    chk("aneg rd", rd, 16'h3100);
    chk("aneg speed", spd, spd_a);
    chk("aneg dup", fdx, fdx_a);
    wr(16'h0800); tk(1);
    chk("pd bit", lowp, 1'h1);
    wr(16'h0000); tk(1);
    chk("pd off", lowp, 1'h0);
    @(posedge clock) lpd <= 1'h1;
    tk(1);
    chk("pd link", lowp, 1'h1);
    @(posedge clock) lpd <= 1'h0;
    wr(16'h1200);
    hits = 0;
    // Pulse stands from the accepting edge to the next one, so look inside it
    #1;
    for (n = 0; n < 4; n++) begin
      hits += (rst_p === 1'h1);
      tk(1);
    end
    chk("restart pulses", 16'(hits), 16'h0001);
    chk("restart clr", rd, 16'h1100);
    wr(16'h0000);
    @(posedge clock) host_tx <= '{1'h1, 4'hA};
    line_rx <= '{1'h1, 4'h5};
    tk(2);
    chk("rx path", 16'(host_rx), 16'h0015);
    chk("tx path", 16'(line_tx), 16'h001A);
    wr(16'h0400); tk(2);
    chk("iso rx", 16'(host_rx), 16'h0000);
    chk("iso tx", 16'(line_tx), 16'h0000);
    @(posedge clock) mlb <= 1'h1;
    wr(16'h0000); tk(1);
    chk("mdi lb", mlen, 1'h1);
    wr(16'h4000); tk(1);
    chk("lb wins", mlen, 1'h0);
    chk("lb dup", fdx, 1'h1);
    tk(18);
    chk("dead gap", 16'(host_rx.en), 16'h0000);
    tk(60);
    chk("loop rx", 16'(host_rx), 16'h001A);
    wr(16'h8000); tk(2);
    chk("busy", srst, 1'h1);
    chk("busy rd", 16'(rd[15]), 16'h0001);
    wr(16'h0800); tk(1);
    chk("wr refused", lowp, 1'h0);
    u_mgmt_host_model.poll(ok);
    chk("poll", ok, 1'h1);
    chk("reset rd", rd, 16'h3180);
    chk("lb cleared", mlen, 1'h1);
    final_report;
  end
endmodule // phy_control_register_tb
